// ===== activity_pkg.sv
// Package of register map, field layout and timing constants for the activity detector
`default_nettype none

package activity_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_LEVEL_HIGH    = 8'h39;
    localparam logic [7:0] ADDR_LEVEL_LOW     = 8'h3a;
    localparam logic [7:0] ADDR_DURATION_HIGH = 8'h3b;
    localparam logic [7:0] ADDR_DURATION_MID  = 8'h3c;
    localparam logic [7:0] ADDR_DURATION_LOW  = 8'h3d;

    // ==========================================================
    // Widths and field layout
    localparam int SAMPLE_W    = 12;
    localparam int LEVEL_W     = 11;
    localparam int LEVEL_HI_W  = 3;
    localparam int DURATION_W  = 24;
    localparam int AXES        = 3;
    localparam int SCALE_SHIFT = 4;                // Times 16
    localparam int SCALED_W    = SAMPLE_W + SCALE_SHIFT;

    // ==========================================================
    // Reset values and the one-step increment
    localparam logic [7:0]            REG_RESET      = 8'h00;
    localparam logic [DURATION_W-1:0] DURATION_ZERO  = 24'h00_0000;
    localparam logic [DURATION_W-1:0] DURATION_ONE   = 24'h00_0001;

    // ==========================================================
    // Activity enable codes
    localparam logic [1:0] ACT_ABSOLUTE   = 2'h1;
    localparam logic [1:0] ACT_REFERENCED = 2'h3;

    // ==========================================================
    // Timing: one duration step
    localparam int TICK_TIME_NS  = 500000;         // 500 us
    localparam int CLK_PERIOD_NS = 10;             // 100 MHz
    localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Detector states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WATCH = 2'b01,
        ST_FIRED = 2'b10
    } detect_state_t;

endpackage : activity_pkg

`default_nettype wire

// ===== axis_level_compare.sv
// Magnitude of one signed axis sample, scaled, compared with the activity level
`timescale 1ns/1ps
`default_nettype none

module axis_level_compare
    import activity_pkg::*;
(
    // Sample and configuration
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic                axisEnable,
    input  wire logic [LEVEL_W-1:0]  level,
    // Result
    output logic                     above
);

    logic [SAMPLE_W-1:0] magnitude;
    logic [SCALED_W-1:0] scaled;

    // ==========================================================
    // Absolute value; the most negative code maps to 2048, which still fits unsigned
    always_comb begin
        magnitude = sample[SAMPLE_W-1] ? SAMPLE_W'(~sample + 1'b1) : sample;
        scaled    = {magnitude, {SCALE_SHIFT{1'b0}}};
        // Raw codes only: a range change does not rescale the level
        above     = axisEnable && (scaled > SCALED_W'(level));
    end

endmodule : axis_level_compare

`default_nettype wire

// ===== step_tick_divider.sv
// Divider producing a one-cycle pulse once per duration step
`timescale 1ns/1ps
`default_nettype none

module step_tick_divider
    import activity_pkg::*;
#(
    parameter int DIVIDE = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic restart,
    // Step pulse
    output logic      tick
);

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } div_state_t;

    div_state_t cur_r;
    div_state_t cur_nxt;

    // ==========================================================
    // Restart aligns the first step with the start of a watch period
    always_comb begin
        cur_nxt      = cur_r;
        cur_nxt.tick = 1'b0;
        if (restart) begin
            cur_nxt.count = 32'h0000_0000;
        end else if (cur_r.count == 32'(DIVIDE - 1)) begin
            cur_nxt.count = 32'h0000_0000;
            cur_nxt.tick  = 1'b1;
        end else begin
            cur_nxt.count = cur_r.count + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign tick = cur_r.tick;

endmodule : step_tick_divider

`default_nettype wire

// ===== activity_detector.sv
// Activity threshold and duration detector with its five byte registers
`timescale 1ns/1ps
`default_nettype none

// Operation
// - The activity level is 11 bits unsigned, bits 10:8 in the high level register bits 2:0 and bits 7:0 in the low.
// - Each enabled axis sample's magnitude is compared with the activity level.
// - The 12-bit sample is shifted left four places (times 16) before comparison.
// - The level is in raw sample codes and is never rescaled for a range change.
// - The duration is 24 bits from the high (23:16), mid (15:8) and low (7:0) registers.
// - One duration step lasts 500 us.
// - With a nonzero duration an event fires only after every valid sample has some enabled axis above for the whole duration.
// - All five registers reset to zero and are readable and writable.
// - A 3-bit axis select picks which of X, Y and Z take part; zero picks none.
// - The detector runs only for enable codes 01 and 11; 00 and 10 hold it stopped.
module activity_detector
    import activity_pkg::*;
#(
    parameter int STEP_CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    // Register port
    input  wire logic [7:0]          regAddr,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    input  wire logic [7:0]          regWrData,
    output logic      [7:0]          regRdData,
    output logic                     regRdValid,
    // Neighbouring control fields
    input  wire logic [1:0]          activityEnable,
    input  wire logic [AXES-1:0]     motionAxisSelect,
    // Sample stream from the datapath
    input  wire logic                sampleValid,
    input  wire logic [SAMPLE_W-1:0] sampleX,
    input  wire logic [SAMPLE_W-1:0] sampleY,
    input  wire logic [SAMPLE_W-1:0] sampleZ,
    // Detection results
    output logic                     activityEvent,
    output logic                     activityHeld,
    output logic                     detectorRunning
);

    // ==========================================================
    // All state of the block except the step divider count, which sits in u_step
    typedef struct packed {
        logic [LEVEL_HI_W-1:0] levelHigh;
        logic [7:0]            levelLow;
        logic [7:0]            durationHigh;
        logic [7:0]            durationMid;
        logic [7:0]            durationLow;
        logic [7:0]            rdData;
        logic                  rdValid;
        detect_state_t         state;
        logic [DURATION_W-1:0] stepCount;
        logic                  pulse;
    } core_state_t;

    core_state_t cur_r;
    core_state_t cur_nxt;

    logic [LEVEL_W-1:0]    activityLevel;
    logic [DURATION_W-1:0] duration;
    logic                  running;
    logic [AXES-1:0]       axisAbove;
    logic                  anyAbove;
    logic                  stepTick;
    logic                  stepRestart;
    logic [SAMPLE_W-1:0]   samples [AXES];

    // ==========================================================
    // Assembled fields
    assign activityLevel = {cur_r.levelHigh, cur_r.levelLow};
    assign duration      = {cur_r.durationHigh, cur_r.durationMid, cur_r.durationLow};
    // Referenced mode compares like absolute here; the reference path sits elsewhere
    assign running       = (activityEnable == ACT_ABSOLUTE) || (activityEnable == ACT_REFERENCED);

    assign samples[0] = sampleX;
    assign samples[1] = sampleY;
    assign samples[2] = sampleZ;

    // ==========================================================
    // One comparator per axis
    for (genvar a = 0; a < AXES; a++) begin : g_axis
        axis_level_compare u_cmp (
            .sample     (samples[a]),
            .axisEnable (motionAxisSelect[a]),
            .level      (activityLevel),
            .above      (axisAbove[a])
        );
    end

    assign anyAbove = |axisAbove;

    // ==========================================================
    // Step divider: held in restart outside a watch period, so each
    // period measures whole steps from its first above-level sample
    assign stepRestart = !running || (cur_r.state != ST_WATCH);

    step_tick_divider #(
        .DIVIDE (STEP_CYCLES)
    ) u_step (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .restart  (stepRestart),
        .tick     (stepTick)
    );

    // ==========================================================
    // Next-state logic: registers, read path and detector
    always_comb begin
        cur_nxt         = cur_r;
        cur_nxt.pulse   = 1'b0;
        cur_nxt.rdValid = regRead;

        // Register writes; reserved high-level bits are dropped
        if (regWrite) begin
            case (regAddr)
                ADDR_LEVEL_HIGH:    cur_nxt.levelHigh    = regWrData[LEVEL_HI_W-1:0];
                ADDR_LEVEL_LOW:     cur_nxt.levelLow     = regWrData;
                ADDR_DURATION_HIGH: cur_nxt.durationHigh = regWrData;
                ADDR_DURATION_MID:  cur_nxt.durationMid  = regWrData;
                ADDR_DURATION_LOW:  cur_nxt.durationLow  = regWrData;
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses answer zero
        if (regRead) begin
            case (regAddr)
                ADDR_LEVEL_HIGH:    cur_nxt.rdData = {5'h0, cur_r.levelHigh};
                ADDR_LEVEL_LOW:     cur_nxt.rdData = cur_r.levelLow;
                ADDR_DURATION_HIGH: cur_nxt.rdData = cur_r.durationHigh;
                ADDR_DURATION_MID:  cur_nxt.rdData = cur_r.durationMid;
                ADDR_DURATION_LOW:  cur_nxt.rdData = cur_r.durationLow;
                default:            cur_nxt.rdData = REG_RESET;
            endcase
        end

        // Detector
        if (!running) begin
            // Stopped modes force the detector back to ST_IDLE and clear the step count
            cur_nxt.state     = ST_IDLE;
            cur_nxt.stepCount = DURATION_ZERO;
        end else begin
            case (cur_r.state)
                ST_IDLE: begin
                    if (sampleValid && anyAbove) begin
                        if (duration == DURATION_ZERO) begin
                            cur_nxt.pulse = 1'b1;
                            cur_nxt.state = ST_FIRED;
                        end else begin
                            cur_nxt.state     = ST_WATCH;
                            cur_nxt.stepCount = DURATION_ZERO;
                        end
                    end
                end
                ST_WATCH: begin
                    if (sampleValid && !anyAbove) begin
                        // Brief motion is forgotten
                        cur_nxt.state     = ST_IDLE;
                        cur_nxt.stepCount = DURATION_ZERO;
                    end else if (stepTick) begin
                        cur_nxt.stepCount = cur_r.stepCount + DURATION_ONE;
                        // Duration may be lowered mid-watch, so compare with >=
                        if (cur_nxt.stepCount >= duration) begin
                            cur_nxt.pulse = 1'b1;
                            cur_nxt.state = ST_FIRED;
                        end
                    end
                end
                ST_FIRED: begin
                    // One event per episode: re-arm only after motion ends
                    if (sampleValid && !anyAbove) begin
                        cur_nxt.state     = ST_IDLE;
                        cur_nxt.stepCount = DURATION_ZERO;
                    end
                end
                default: begin
                    cur_nxt.state     = ST_IDLE;
                    cur_nxt.stepCount = DURATION_ZERO;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_r           <= '0;
            cur_r.state     <= ST_IDLE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Outputs
    assign regRdData       = cur_r.rdData;
    assign regRdValid      = cur_r.rdValid;
    assign activityEvent   = cur_r.pulse;
    assign activityHeld    = (cur_r.state == ST_FIRED);
    assign detectorRunning = running;

endmodule : activity_detector

`default_nettype wire

// ===== activity_detector_props.sv
// Checker of register port and detector timing for the activity detector
`timescale 1ns/1ps
`default_nettype none

module activity_detector_props
    import activity_pkg::*;
#(
    parameter int STEP_CYCLES = TICK_CYCLES
) (
    // Clock, reset and strobes
    input wire logic                core_clk, sys_rst, regWrite, regRead, sampleValid,
    // Register data
    input wire logic [7:0]          regAddr, regWrData, regRdData,
    // Control and samples
    input wire logic [1:0]          activityEnable,
    input wire logic [AXES-1:0]     motionAxisSelect,
    input wire logic [SAMPLE_W-1:0] sampleX, sampleY, sampleZ,
    // Results
    input wire logic                regRdValid, activityEvent, activityHeld, detectorRunning
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Register port
    a_read_answer: assert property (regRead |=> regRdValid) else $error("read got no answer");
    a_answer_cause: assert property (regRdValid |-> $past(regRead)) else $error("answer without read");
    a_unmapped_zero: assert property (regRead && (regAddr < ADDR_LEVEL_HIGH || regAddr > ADDR_DURATION_LOW)
        |=> regRdData == 8'h00) else $error("unmapped read not zero");
    a_level_reserved: assert property (regRead && regAddr == ADDR_LEVEL_HIGH |=> regRdData[7:3] == 5'h00)
        else $error("reserved level bits not zero");
    // Reset must clear outputs even though the default disable is the reset itself
    a_reset_clear: assert property (@(posedge core_clk) disable iff (1'b0)
        sys_rst |=> !activityEvent && !activityHeld && !regRdValid) else $error("reset left outputs set");

    // ==========================================================
    // Detector
    a_run_codes: assert property (detectorRunning == activityEnable[0]) else $error("run flag wrong");
    a_stop_quiet: assert property (!detectorRunning |=> !activityEvent) else $error("event while stopped");
    a_event_pulse: assert property (activityEvent |=> !activityEvent) else $error("event longer than one");
    a_event_held: assert property (activityEvent |-> activityHeld) else $error("event without held");

    // Main scenarios
    c_event: cover property (activityEvent);
    c_read: cover property (regRdValid);
    c_rearm: cover property ($fell(activityHeld));
endmodule : activity_detector_props

bind activity_detector activity_detector_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead), .sampleValid(sampleValid),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .activityEnable(activityEnable),
    .motionAxisSelect(motionAxisSelect), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
    .regRdValid(regRdValid), .activityEvent(activityEvent), .activityHeld(activityHeld),
    .detectorRunning(detectorRunning));

`default_nettype wire

// ===== tb.sv
// Self-checking testbench of the activity detector
`timescale 1ns/1ps
`default_nettype none

module tb;
    import activity_pkg::*;
    localparam int STEP = 4;            // Short step keeps the run brief
    localparam int DUR  = 3;
    logic                core_clk, sys_rst, regWrite, regRead, sampleValid;
    logic                regRdValid, activityEvent, activityHeld, detectorRunning;
    logic [7:0]          regAddr, regWrData, regRdData, wd, ad;
    logic [1:0]          activityEnable;
    logic [2:0]          motionAxisSelect, sel;
    logic [SAMPLE_W-1:0] sampleX, sampleY, sampleZ, sx;
    logic [10:0]         lvl;
    logic                held, ab;
    int                  miscompares, comparisons, seed, cnt;

    activity_detector #(.STEP_CYCLES(STEP)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .activityEnable(activityEnable),
        .motionAxisSelect(motionAxisSelect), .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY),
        .sampleZ(sampleZ), .activityEvent(activityEvent), .activityHeld(activityHeld),
        .detectorRunning(detectorRunning));

    // ==========================================================
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end

    // ==========================================================
    // Shared tasks
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a; regWrData <= d; regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read answers one cycle after the strobe edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a; regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        check("read valid", regRdValid, 1);
        d = regRdData;
    endtask : rd
    task samp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z, input logic [2:0] s);
        @(posedge core_clk);
        sampleX <= x; sampleY <= y; sampleZ <= z; motionAxisSelect <= s; sampleValid <= 1'b1;
        @(posedge core_clk);
        sampleValid <= 1'b0;
        #1;
    endtask : samp
    // Any enabled axis with magnitude times 16 strictly above the level
    function automatic logic aboveExp(input logic [35:0] s, input logic [2:0] en, input logic [10:0] l);
        int v;
        aboveExp = 1'b0;
        for (int i = 0; i < 3; i++) begin
            v = $signed(s[i*12+:12]);
            if (v < 0) v = -v;
            if (en[i] && v * 16 > int'(l)) aboveExp = 1'b1;
        end
    endfunction : aboveExp

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h4001_780d;
        {sys_rst, regWrite, regRead, sampleValid} = 4'h8;
        {regAddr, regWrData, activityEnable, motionAxisSelect} = '0;
        {sampleX, sampleY, sampleZ} = '0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 8'h38; a <= 8'h3e; a++) begin
            rd(8'(a), wd);
            check("reset value", wd, 0);
        end
        for (int i = 0; i < 24; i++) begin
            ad = 8'h38 + 8'($random(seed) & 7);
            wd = 8'($random(seed));
            wr(ad, wd);
            rd(ad, sx[7:0]);
            check("read back", sx[7:0], (ad < 8'h39 || ad > 8'h3d) ? 0 : (ad == 8'h39) ? wd & 8'h07 : wd);
        end
        $display("test registers done");
        wr(ADDR_DURATION_HIGH, 8'h00); wr(ADDR_DURATION_MID, 8'h00); wr(ADDR_DURATION_LOW, 8'h00);
        activityEnable <= ACT_ABSOLUTE;
        held = 1'b0;
        for (int i = 0; i < 200; i++) begin
            if (i % 25 == 0) begin
                lvl = 11'($random(seed));
                wr(ADDR_LEVEL_HIGH, {5'h1f, lvl[10:8]});
                wr(ADDR_LEVEL_LOW, lvl[7:0]);
            end
            sel = 3'($random(seed));
            sx = (i == 0) ? 12'h800 : 12'($random(seed) % 160);
            samp(sx, 12'($random(seed) % 140), 12'h005, sel);
            ab = aboveExp({12'h005, sampleY, sx}, sel, lvl);
            check("event", activityEvent, ab && !held);
            check("held", activityHeld, ab);
            held = ab;
        end
        $display("test zero duration done");
        for (int c = 0; c < 4; c++) begin
            samp(12'h000, 12'h000, 12'h000, 3'h7);
            @(posedge core_clk);
            activityEnable <= 2'(c);
            #1;
            check("running", detectorRunning, c % 2);
            samp(12'h7ff, 12'h7ff, 12'h7ff, 3'h7);
            check("enable code event", activityEvent, c % 2);
            activityEnable <= ACT_REFERENCED;
        end
        $display("test enable codes done");
        wr(ADDR_DURATION_LOW, 8'(DUR));
        samp(12'h000, 12'h000, 12'h000, 3'h7);
        samp(12'h7ff, 12'h000, 12'h000, 3'h1);
        for (cnt = 0; cnt < 100 && activityEvent !== 1'b1; cnt++) @(posedge core_clk) #1;
        check("duration", cnt >= DUR * STEP && cnt <= DUR * STEP + 2, 1);
        samp(12'h000, 12'h000, 12'h000, 3'h7);
        samp(12'h7ff, 12'h000, 12'h000, 3'h1);
        repeat (STEP) @(posedge core_clk);
        samp(12'h000, 12'h000, 12'h000, 3'h7);
        cnt = 0;
        repeat (DUR * STEP + 4) @(posedge core_clk) #1 cnt += int'(activityEvent !== 1'b0);
        check("restart", cnt, 0);
        $display("test duration done");
        end_of_test();
    end
endmodule : tb

`default_nettype wire
